// file: rtl/dpsf_host_ctrl.sv
/*
  dpsf_host_ctrl: apb-controlled master for the semaphore space of one ram port.
  assumes data_in comes straight from the pin and a bench resolves the data wire.
*/
// Operation
// RL1: eight flags, addressed apart from ram space.
// RL2: flags active low; write zero requests, write one releases.
// RL3: semaphore select low selects token space; other controls as sram.
// RL4: only three low index lines pick the flag.
// RL5: only data bit zero counts on a semaphore write.
// RL6: zero to free flag: writer reads zero, other side reads one.
// RL7: owner writes one: flag freed unless other side pending.
// RL8: other side's zero is held in its request latch.
// RL9: pending request takes ownership when owner releases.
// RL10: read spreads the flag over all eight data bits.
// RL11: device latches read value while select and output enable active.
// RL12: polling deasserts select or output enable between reads.
// RL13: acquire by writing zero then reading back; zero means granted.
// RL14: after failure, keep re-reading or write one to withdraw; code re-reads retry_r times, withdraws only if wdraw_r set.
// RL15: simultaneous requests: exactly one side wins.
// RL16: after power-up write one to all eight flags.
// RL17: port standby while both port and semaphore select high.
// RL18: flags control no hardware resource.
// RL19: semaphore accesses insert no wait states.
// RL20: semaphore access only with port select high, semaphore select low.
// RL21: write is taken on low read/write level while semaphore selected.
// RL22: request latches unknown after power-up until written.
`timescale 1ns/100ps
module dpsf_host_ctrl
  import dpsf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output dpsf_pins_t       pins,
  input  wire logic [7:0]  data_in
);

  dpsf_state_t      state_r;
  dpsf_cmd_t        cmd_r;
  logic [2:0]       idx_r;
  logic             wval_r;
  logic             last_wr_r;
  logic             withdrawn_r;
  logic [7:0]       tries_r;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0]       sync1_r;
  logic [7:0]       sync2_r;
  logic [7:0]       rbyte_r;
  logic [7:0]       owned_r;
  logic             grant_r;
  logic             done_pulse_r;
  logic             done_r;
  logic             refused_r;
  logic [7:0]       retry_r;
  logic             wdraw_r;
  logic [31:0]      prdata_r;
  dpsf_pins_t       pins_r;

  logic access;
  logic wr_ctrl;
  logic wr_status;
  logic wr_cfg;
  logic mapped;
  logic busy;
  logic cnt_end;

  assign busy      = (state_r != S_IDLE);
  assign cnt_end   = (cnt_r == '0);
  assign access    = psel & penable;
  assign mapped    = (paddr == REG_CTRL) | (paddr == REG_STATUS) |
                     (paddr == REG_CFG) | (paddr == REG_OWNED);
  assign wr_ctrl   = access & pwrite & (paddr == REG_CTRL);
  assign wr_status = access & pwrite & (paddr == REG_STATUS);
  assign wr_cfg    = access & pwrite & (paddr == REG_CFG);
  assign pready    = 1'b1;
  assign pslverr   = access & ~mapped;
  assign prdata    = prdata_r;
  assign pins      = pins_r;

  // read data is fetched in the setup cycle, answered in the access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      case (paddr)
        REG_CTRL:   prdata_r <= {23'h0, wval_r, 1'b0, idx_r, 1'b0, cmd_r};
        REG_STATUS: prdata_r <= {16'h0, rbyte_r, 4'h0, refused_r, grant_r, done_r, busy};
        REG_CFG:    prdata_r <= {23'h0, wdraw_r, retry_r};
        REG_OWNED:  prdata_r <= {24'h0, owned_r};
        default:    prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      retry_r <= CFG_RETRY_RST;
      wdraw_r <= CFG_WDRAW_RST;
    end else if (wr_cfg) begin
      retry_r <= pwdata[7:0];
      wdraw_r <= pwdata[CFG_WDRAW_BIT];
    end
  end

  // sticky status, hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      done_r    <= (done_r & ~(wr_status & pwdata[ST_DONE_BIT])) | done_pulse_r;
      refused_r <= (refused_r & ~(wr_status & pwdata[ST_REFUS_BIT])) | (wr_ctrl & busy);
    end
  end

  // data pins cross into the clock domain through two flops
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= data_in;
      sync2_r <= sync1_r;
    end
  end

  // access sequencer and pin drive
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r      <= S_IDLE;
      cmd_r        <= CMD_NONE;
      idx_r        <= 3'h0;
      wval_r       <= 1'b1;
      last_wr_r    <= 1'b0;
      withdrawn_r  <= 1'b0;
      tries_r      <= 8'h00;
      cnt_r        <= '0;
      rbyte_r      <= 8'h00;
      owned_r      <= 8'h00;
      grant_r      <= 1'b0;
      done_pulse_r <= 1'b0;
      pins_r       <= PINS_IDLE;
    end else begin
      done_pulse_r <= 1'b0;
      if (~cnt_end) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
      case (state_r)
        S_IDLE: begin
          pins_r <= PINS_IDLE; // [RL17]
          if (wr_ctrl) begin
            cmd_r       <= dpsf_cmd_t'(pwdata[CTRL_CMD_LSB +: 3]);
            idx_r       <= pwdata[CTRL_IDX_LSB +: 3]; // [RL1] [RL4]
            wval_r      <= pwdata[CTRL_VAL_BIT];
            withdrawn_r <= 1'b0;
            tries_r     <= 8'h00;
            case (dpsf_cmd_t'(pwdata[CTRL_CMD_LSB +: 3]))
              CMD_WRITE: begin
                state_r <= S_WSET;
              end
              CMD_READ: begin
                state_r <= S_RWAIT;
              end
              CMD_ACQUIRE: begin
                wval_r  <= 1'b0; // [RL2] [RL13]
                grant_r <= 1'b0;
                state_r <= S_WSET;
              end
              CMD_RELEASE: begin
                wval_r  <= 1'b1; // [RL2]
                state_r <= S_WSET;
              end
              CMD_INIT: begin
                idx_r   <= 3'h0; // [RL16] [RL22]
                wval_r  <= 1'b1;
                state_r <= S_WSET;
              end
              default: begin
                done_pulse_r <= 1'b1;
              end
            endcase
            if (pwdata[CTRL_CMD_LSB +: 3] == CMD_READ) begin
              cnt_r <= CNT_W'(RD_CYC);
            end else begin
              cnt_r <= CNT_W'(AS_CYC);
            end
          end
        end
        S_WSET: begin
          pins_r.port_select_n        <= 1'b1; // [RL20]
          pins_r.token_space_select_n <= 1'b0; // [RL3]
          pins_r.flag_index           <= idx_r;
          pins_r.data_out             <= {8{wval_r}}; // [RL5]
          pins_r.data_oe              <= 1'b1;
          if (cnt_end) begin
            pins_r.rw_n <= 1'b0; // [RL21]
            cnt_r       <= CNT_W'(WP_CYC - 1);
            state_r     <= S_WPULSE;
          end
        end
        S_WPULSE: begin
          if (cnt_end) begin
            pins_r.rw_n <= 1'b1; // [RL21]
            cnt_r       <= CNT_W'(DH_CYC - 1);
            state_r     <= S_WHOLD;
          end
        end
        S_WHOLD: begin
          if (cnt_end) begin
            pins_r    <= PINS_IDLE;
            last_wr_r <= 1'b1;
            cnt_r     <= CNT_W'(GAP_CYC - 1);
            state_r   <= S_GAP;
          end
        end
        S_RWAIT: begin
          pins_r.port_select_n        <= 1'b1; // [RL20]
          pins_r.token_space_select_n <= 1'b0; // [RL3] [RL11]
          pins_r.oe_n                 <= 1'b0;
          pins_r.rw_n                 <= 1'b1;
          pins_r.flag_index           <= idx_r;
          pins_r.data_oe              <= 1'b0;
          if (cnt_end) begin
            rbyte_r   <= sync2_r; // [RL10]
            pins_r    <= PINS_IDLE; // [RL12]
            last_wr_r <= 1'b0;
            cnt_r     <= CNT_W'(GAP_CYC - 1);
            state_r   <= S_GAP;
          end
        end
        S_GAP: begin
          if (cnt_end) begin
            state_r <= S_IDLE;
            case (cmd_r)
              CMD_ACQUIRE: begin
                if (last_wr_r & ~withdrawn_r) begin
                  cnt_r   <= CNT_W'(RD_CYC); // [RL13]
                  state_r <= S_RWAIT;
                end else if (last_wr_r) begin
                  done_pulse_r <= 1'b1;
                end else if (~rbyte_r[0]) begin
                  grant_r        <= 1'b1; // [RL6] [RL9] [RL15]
                  owned_r[idx_r] <= 1'b1; // [RL18]
                  done_pulse_r   <= 1'b1;
                end else if (tries_r < retry_r) begin
                  tries_r <= tries_r + 8'h01; // [RL14] [RL8]
                  cnt_r   <= CNT_W'(RD_CYC);
                  state_r <= S_RWAIT;
                end else if (wdraw_r) begin
                  wval_r      <= 1'b1; // [RL14]
                  withdrawn_r <= 1'b1;
                  cnt_r       <= CNT_W'(AS_CYC);
                  state_r     <= S_WSET;
                end else begin
                  done_pulse_r <= 1'b1;
                end
              end
              CMD_RELEASE: begin
                owned_r[idx_r] <= 1'b0; // [RL7]
                done_pulse_r   <= 1'b1;
              end
              CMD_INIT: begin
                if (idx_r == LAST_FLAG) begin
                  owned_r      <= 8'h00;
                  done_pulse_r <= 1'b1;
                end else begin
                  idx_r   <= idx_r + 3'h1; // [RL16]
                  cnt_r   <= CNT_W'(AS_CYC);
                  state_r <= S_WSET;
                end
              end
              CMD_WRITE: begin
                owned_r[idx_r] <= owned_r[idx_r] & wval_r ? 1'b0 : owned_r[idx_r];
                done_pulse_r   <= 1'b1;
              end
              default: begin
                done_pulse_r <= 1'b1; // [RL19]
              end
            endcase
          end
        end
        default: begin
          state_r <= S_IDLE;
          pins_r  <= PINS_IDLE;
        end
      endcase
    end
  end

endmodule

// file: rtl/dpsf_pkg.sv
/*
  dpsf_pkg: constants, register map and types for the semaphore port controller.
  assumes one 40 MHz clock and one port of an asynchronous dual-port ram.
*/
package dpsf_pkg;
  // clock and pin timing, times in ns
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_AS_NS       = 5;
  localparam int T_WP_NS       = 55;
  localparam int T_DH_NS       = 5;
  localparam int T_ACC_NS      = 55;
  localparam int T_GAP_NS      = 25;
  localparam int SYNC_STAGES   = 2;
  localparam int AS_CYC   = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DH_CYC   = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC  = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC   = ACC_CYC + SYNC_STAGES;
  localparam int CNT_W    = 4;

  // flags on the device
  localparam int          NUM_FLAGS = 8;
  localparam logic [2:0]  LAST_FLAG = 3'h7;

  // register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG    = 8'h08;
  localparam logic [7:0] REG_OWNED  = 8'h0C;

  // field positions
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_IDX_LSB = 4;
  localparam int CTRL_VAL_BIT = 8;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_GRANT_BIT = 2;
  localparam int ST_REFUS_BIT = 3;
  localparam int ST_BYTE_LSB  = 8;
  localparam int CFG_WDRAW_BIT = 8;

  // reset values
  localparam logic [7:0] CFG_RETRY_RST = 8'h00;
  localparam logic       CFG_WDRAW_RST = 1'b1;

  typedef enum logic [2:0] {
    CMD_NONE    = 3'b000,
    CMD_WRITE   = 3'b001,
    CMD_READ    = 3'b010,
    CMD_ACQUIRE = 3'b011,
    CMD_RELEASE = 3'b100,
    CMD_INIT    = 3'b101
  } dpsf_cmd_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_WSET   = 3'b001,
    S_WPULSE = 3'b010,
    S_WHOLD  = 3'b011,
    S_RWAIT  = 3'b100,
    S_GAP    = 3'b101
  } dpsf_state_t;

  // pins driven toward the device port
  typedef struct packed {
    logic       port_select_n;
    logic       token_space_select_n;
    logic       rw_n;
    logic       oe_n;
    logic [2:0] flag_index;
    logic [7:0] data_out;
    logic       data_oe;
  } dpsf_pins_t;

  localparam dpsf_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 8'h00, 1'b0};
endpackage

// file: sim/dpsf_dev_model.sv
/* dpsf_dev_model: behavioural semaphore flags of both device ports.
   assumes the left port is the controller's pins and the right port is poked by the bench. */
`timescale 1ns/100ps
module dpsf_dev_model
  import dpsf_pkg::*;
(
  input  wire dpsf_pins_t pins,
  input  wire logic       r_we,
  input  wire logic [2:0] r_idx,
  input  wire logic       r_val,
  output logic      [7:0] r_flag,
  output logic      [7:0] l_drv
);
  // flags gate nothing, owners are software tokens only
  logic [7:0] req_l = 8'hXX;
  logic [7:0] req_r = 8'hXX;
  logic [7:0] own_l = 8'h00;
  logic [7:0] own_r = 8'h00;
  logic [7:0] l_q   = 8'h00;
  task automatic settle(input logic l_first);
    for (int i = 0; i < NUM_FLAGS; i++) begin
      if (own_l[i] && req_l[i] === 1'b1) own_l[i] = 1'b0;
      if (own_r[i] && req_r[i] === 1'b1) own_r[i] = 1'b0;
      if (!own_l[i] && !own_r[i]) begin
        if (req_l[i] === 1'b0 && (l_first || req_r[i] !== 1'b0)) own_l[i] = 1'b1;
        else if (req_r[i] === 1'b0) own_r[i] = 1'b1;
      end
    end
  endtask
  always @(posedge pins.rw_n) begin
    if (!pins.token_space_select_n && pins.port_select_n) begin
      req_l[pins.flag_index] = pins.data_out[0];
      settle(1'b1);
    end
  end
  always @(posedge r_we) begin
    req_r[r_idx] = r_val;
    settle(1'b0);
  end
  always @(negedge (pins.token_space_select_n | pins.oe_n)) begin
    l_q = {8{~own_l[pins.flag_index]}};
  end
  assign r_flag = ~own_r;
  // answers at once; released or standby wire shows the inverse
  assign l_drv = (!pins.token_space_select_n && !pins.oe_n) ? l_q : ~l_q;
endmodule

// file: sim/dpsf_host_chk.sv
/* dpsf_host_chk: pin and bus timing checks of the semaphore port controller.
   assumes it is bound to dpsf_host_ctrl and sees only its ports. */
`timescale 1ns/100ps
module dpsf_host_chk
  import dpsf_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire dpsf_pins_t  pins,
  input wire logic [7:0]  data_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence wr_pulse_s;
    !pins.rw_n [*3] ##1 (pins.rw_n && pins.data_oe && !pins.token_space_select_n);
  endsequence
  sequence rd_win_s;
    (!pins.oe_n && !pins.token_space_select_n) [*5] ##1 pins.oe_n;
  endsequence
  ps_high_a: assert property (pins.port_select_n)
    else $error("port select went low");
  no_wait_a: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  wr_sel_a: assert property (!pins.rw_n |-> !pins.token_space_select_n && pins.oe_n && pins.data_oe)
    else $error("write pulse without select or data");
  wr_setup_a: assert property ($fell(pins.token_space_select_n) && pins.data_oe |-> pins.rw_n ##1 !pins.rw_n)
    else $error("write setup cycle wrong");
  wr_len_a: assert property ($fell(pins.rw_n) |-> wr_pulse_s ##1 !pins.data_oe)
    else $error("write pulse length wrong");
  rd_len_a: assert property ($fell(pins.oe_n) |-> rd_win_s)
    else $error("read window length wrong");
  rd_drive_a: assert property (!pins.oe_n |-> !pins.data_oe && pins.rw_n)
    else $error("data driven during read");
  poll_gap_a: assert property ($rose(pins.token_space_select_n) |=> pins.token_space_select_n && pins.oe_n)
    else $error("no idle gap between accesses");
  data_rep_a: assert property (pins.data_oe |-> pins.data_out inside {8'h00, 8'hFF})
    else $error("written byte not uniform");
endmodule
bind dpsf_host_ctrl dpsf_host_chk dpsf_host_chk_i (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .data_in(data_in));

// file: sim/dual_port_semaphore_flags_test.sv
/* dual_port_semaphore_flags_test: apb-driven scenarios against the flag model.
   assumes the controller, its package and the device model are compiled before. */
`timescale 1ns/100ps
module dual_port_semaphore_flags_test
  import dpsf_pkg::*;
;
  logic        clk     = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        r_we    = 1'b0;
  logic [2:0]  r_idx   = 3'h0;
  logic        r_val   = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  r_flag;
  logic [7:0]  l_drv;
  logic [7:0]  data_in;
  dpsf_pins_t  pins;
  int          err_total  = 0;
  int          n_compared = 0;
  always #12.5 clk = ~clk;
  assign data_in = pins.data_oe ? pins.data_out : l_drv;
  dpsf_host_ctrl dpsf_host_ctrl_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .data_in(data_in));
  dpsf_dev_model dpsf_dev_model_i (.pins(pins), .r_we(r_we), .r_idx(r_idx), .r_val(r_val),
    .r_flag(r_flag), .l_drv(l_drv));
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic do_cmd(input dpsf_cmd_t c, input logic [2:0] i, input logic v);
    logic [31:0] q;
    wr(REG_CTRL, 32'(c) | (32'(i) << CTRL_IDX_LSB) | (32'(v) << CTRL_VAL_BIT));
    q = 32'h0;
    for (int k = 0; k < 60 && q[ST_DONE_BIT] !== 1'b1; k++) rd(REG_STATUS, q);
    check("done", 32'(q[ST_DONE_BIT]), 32'h1);
    wr(REG_STATUS, 32'h2);
  endtask
  task automatic r_write(input logic [2:0] i, input logic v);
    @(posedge clk);
    r_idx <= i;
    r_val <= v;
    r_we  <= 1'b1;
    @(posedge clk);
    r_we  <= 1'b0;
  endtask
  task automatic t_init();
    logic [31:0] q;
    for (int i = 0; i < NUM_FLAGS; i++) r_write(3'(i), 1'b1);
    do_cmd(CMD_INIT, 3'h0, 1'b0);
    check("req_l", 32'(dpsf_dev_model_i.req_l), 32'hFF);
    rd(REG_OWNED, q);
    check("owned", q, 32'h0);
  endtask
  task automatic t_acquire_handover();
    logic [31:0] q;
    do_cmd(CMD_ACQUIRE, 3'h3, 1'b0);
    rd(REG_STATUS, q);
    check("granted", 32'(q[ST_GRANT_BIT]), 32'h1);
    check("byte", 32'(q[15:8]), 32'h00);
    check("r_flag", 32'(r_flag[3]), 32'h1);
    r_write(3'h3, 1'b0);
    check("r_pend", 32'(r_flag[3]), 32'h1);
    do_cmd(CMD_RELEASE, 3'h3, 1'b0);
    check("r_take", 32'(r_flag[3]), 32'h0);
    rd(REG_OWNED, q);
    check("owned", q, 32'h0);
    do_cmd(CMD_READ, 3'h3, 1'b0);
    rd(REG_STATUS, q);
    check("byte", 32'(q[15:8]), 32'hFF);
    r_write(3'h3, 1'b1);
  endtask
  task automatic t_contend();
    logic [31:0] q;
    wr(REG_CFG, 32'h101);
    r_write(3'h5, 1'b0);
    do_cmd(CMD_ACQUIRE, 3'h5, 1'b0);
    rd(REG_STATUS, q);
    check("granted", 32'(q[ST_GRANT_BIT]), 32'h0);
    check("withdrawn", 32'(dpsf_dev_model_i.req_l[5]), 32'h1);
    r_write(3'h5, 1'b1);
    check("free", 32'(r_flag[5]), 32'h1);
  endtask
  task automatic t_write_read();
    logic [31:0] q;
    logic        e;
    do_cmd(CMD_WRITE, LAST_FLAG, 1'b0);
    check("req7", 32'(dpsf_dev_model_i.req_l), 32'h7F);
    do_cmd(CMD_READ, LAST_FLAG, 1'b0);
    rd(REG_STATUS, q);
    check("byte", 32'(q[15:8]), 32'h00);
    do_cmd(CMD_WRITE, LAST_FLAG, 1'b1);
    check("r7", 32'(r_flag[7]), 32'h1);
    wr(REG_CTRL, 32'(CMD_READ));
    wr(REG_CTRL, 32'(CMD_WRITE));
    rd(REG_STATUS, q);
    check("busy", 32'(q[ST_BUSY_BIT]), 32'h1);
    check("refused", 32'(q[ST_REFUS_BIT]), 32'h1);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check("unmapped", q, 32'h0);
    check("slverr", 32'(e), 32'h1);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_init();
    t_acquire_handover();
    t_contend();
    t_write_read();
    report_and_stop();
  end
endmodule
